// *** design/prs_pc_stack.sv ***
// program counter loading and hardware return stack
//
// Design decisions made here: the placing of the registers and strobed register access.
`timescale 1ns/1ps
module prs_pc_stack #(
   parameter int DEPTH = prs_pkg::DEPTH
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_srst,
   // configuration
   input wire logic i_stack_fault_reset_enable,
   // execute logic
   input wire prs_pkg::prs_cmd_t i_cmd,
   // register port
   input wire prs_pkg::prs_bus_t i_bus,
   output logic [7:0] o_rdata,
   // state
   output logic [prs_pkg::PC_W-1:0] o_pc,
   output logic o_stack_overflow_flag,
   output logic o_stack_underflow_flag,
   output logic o_stack_fault_reset
);

   logic [prs_pkg::PC_W-1:0] pc_ff;
   logic [prs_pkg::PC_W-1:0] nxt_pc;
   logic [prs_pkg::HI_W-1:0] latch_ff;
   logic [prs_pkg::IDX_W-1:0] idx_ff;
   logic [prs_pkg::IDX_W-1:0] nxt_idx;
   logic [prs_pkg::PC_W-1:0] stack_q [DEPTH];
   logic ovf_ff;
   logic unf_ff;
   logic fault_ff;
   logic [7:0] rdata_ff;
   logic push;
   logic pop;
   logic ovf_ev;
   logic unf_ev;
   logic [prs_pkg::PC_W-1:0] pc_inc;
   logic [prs_pkg::PC_W-1:0] tos;
   logic [prs_pkg::PC_W-1:0] pushed;
   logic [3:0] slot;
   logic [3:0] push_slot;
   logic pcl_wr;
   logic latch_wr;
   logic index_wr;
   logic top_of_stack_low_wr;
   logic top_of_stack_high_wr;
   logic status_wr;
   logic ovf_clr;
   logic unf_clr;
   logic fault_ev;
   logic idx_restore;
   logic [prs_pkg::PC_W-1:0] call_target;
   logic [prs_pkg::PC_W-1:0] indirect_subroutine_jump_target;
   logic [prs_pkg::PC_W-1:0] brw_target;
   logic [prs_pkg::PC_W-1:0] bra_target;
   logic [prs_pkg::PC_W-1:0] bra_offset;
   logic [prs_pkg::PC_W-1:0] pcl_target;
   logic [7:0] nxt_rdata;
   logic [DEPTH-1:0] slot_push_wr;
   logic [DEPTH-1:0] slot_lo_wr;
   logic [DEPTH-1:0] slot_hi_wr;

   // ----------------------------------------
   // decode
   // ----------------------------------------
   assign pc_inc = pc_ff + 15'h0001;

   // calls and vectoring push; every return kind pops
   always_comb begin
      push = 1'b0;
      pop = 1'b0;
      unique case (i_cmd.op)
         prs_pkg::PRS_OP_CALL: push = 1'b1;
         prs_pkg::PRS_OP_INDIRECT_SUBROUTINE_JUMP: push = 1'b1;
         prs_pkg::PRS_OP_IRQ: push = 1'b1;
         prs_pkg::PRS_OP_RET: pop = 1'b1;
         default: begin
         end
      endcase
   end

   assign pcl_wr = i_bus.wr && (i_bus.addr == prs_pkg::ADDR_PCL);
   assign slot = idx_ff[3:0];
   assign ovf_ev = push && (idx_ff == prs_pkg::IDX_TOP);
   assign unf_ev = pop && (idx_ff == prs_pkg::IDX_EMPTY);

   // push moves the index up before the write; pop reads before moving down
   always_comb begin
      if (push) begin
         nxt_idx = idx_ff + 5'h01;
      end else if (pop) begin
         nxt_idx = idx_ff - 5'h01;
      end else begin
         nxt_idx = idx_ff;
      end
   end

   assign push_slot = nxt_idx[3:0];
   assign pushed = pc_inc;

   // ----------------------------------------
   // register write decode
   // ----------------------------------------
   assign latch_wr = i_bus.wr && (i_bus.addr == prs_pkg::ADDR_LATCH);
   assign index_wr = i_bus.wr && (i_bus.addr == prs_pkg::ADDR_INDEX);
   assign top_of_stack_low_wr = i_bus.wr && (i_bus.addr == prs_pkg::ADDR_TOP_OF_STACK_LOW);
   assign top_of_stack_high_wr = i_bus.wr && (i_bus.addr == prs_pkg::ADDR_TOP_OF_STACK_HIGH);
   assign status_wr = i_bus.wr && (i_bus.addr == prs_pkg::ADDR_STATUS);

   // writing a zero to a flag bit clears it, a one leaves it alone
   assign ovf_clr = status_wr && !i_bus.wdata[prs_pkg::ST_OVF_BIT];
   assign unf_clr = status_wr && !i_bus.wdata[prs_pkg::ST_UNF_BIT];
   assign fault_ev = ovf_ev || unf_ev;

   // with fault reset on, a faulting push or pop leaves the stack empty
   assign idx_restore = fault_ev && i_stack_fault_reset_enable;

   // ----------------------------------------
   // jump and branch targets
   // ----------------------------------------
   assign call_target = {latch_ff[6:3], i_cmd.operand};
   assign indirect_subroutine_jump_target = {latch_ff, i_cmd.wreg};
   assign pcl_target = {latch_ff, i_bus.wdata};

   // branches start from the already incremented counter
   assign brw_target = pc_inc + {7'h00, i_cmd.wreg};

   // nine-bit signed offset, sign spread over the upper six bits
   assign bra_offset = {{6{i_cmd.operand[8]}}, i_cmd.operand[8:0]};
   assign bra_target = pc_inc + bra_offset;

   // ----------------------------------------
   // top of stack
   // ----------------------------------------

   always_comb begin
      if (idx_ff == prs_pkg::IDX_EMPTY && i_stack_fault_reset_enable) begin
         tos = prs_pkg::PC_RST;
      end else begin
         tos = stack_q[slot];
      end
   end

   // ----------------------------------------
   // program counter
   // ----------------------------------------
   always_comb begin
      nxt_pc = pc_inc;
      unique case (i_cmd.op)
         prs_pkg::PRS_OP_NONE: nxt_pc = pc_ff;
         prs_pkg::PRS_OP_CALL: nxt_pc = call_target;
         prs_pkg::PRS_OP_INDIRECT_SUBROUTINE_JUMP: nxt_pc = indirect_subroutine_jump_target;
         prs_pkg::PRS_OP_BRW: nxt_pc = brw_target;
         prs_pkg::PRS_OP_BRA: nxt_pc = bra_target;
         prs_pkg::PRS_OP_RET: nxt_pc = tos;
         prs_pkg::PRS_OP_IRQ: nxt_pc = i_cmd.vector;
         prs_pkg::PRS_OP_INC: nxt_pc = pc_inc;
      endcase
      // a software write of the low byte overrides the execute request
      if (pcl_wr) begin
         nxt_pc = pcl_target;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         pc_ff <= prs_pkg::PC_RST;
      end else begin
         pc_ff <= nxt_pc;
      end
   end

   // latch: only software writes it, never the stack
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         latch_ff <= prs_pkg::LATCH_RST;
      end else if (latch_wr) begin
         latch_ff <= i_bus.wdata[6:0];
      end
   end

   // ----------------------------------------
   // stack index and storage
   // ----------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         idx_ff <= prs_pkg::IDX_EMPTY;
      end else if (push || pop) begin
         // index writes are refused while the execute side moves the stack
         idx_ff <= idx_restore ? prs_pkg::IDX_EMPTY : nxt_idx;
      end else if (index_wr) begin
         idx_ff <= i_bus.wdata[4:0];
      end
   end

   // three write enables per entry (push, low, high); a push beats a software write to the top
   always_comb begin
      slot_push_wr = '0;
      slot_lo_wr = '0;
      slot_hi_wr = '0;
      if (push) begin
         slot_push_wr[push_slot] = 1'b1;
      end else if (top_of_stack_low_wr) begin
         slot_lo_wr[slot] = 1'b1;
      end else if (top_of_stack_high_wr) begin
         slot_hi_wr[slot] = 1'b1;
      end
   end

   for (genvar g = 0; g < DEPTH; g++) begin : g_slot
      prs_stack_slot u_slot (
         .i_clk(i_clk),
         .i_push_wr(slot_push_wr[g]),
         .i_lo_wr(slot_lo_wr[g]),
         .i_hi_wr(slot_hi_wr[g]),
         .i_push_data(pushed),
         .i_wdata(i_bus.wdata),
         .o_q(stack_q[g])
      );
   end

   // ----------------------------------------
   // fault flags and reset request
   // ----------------------------------------
   // set wins over a same-cycle software clear
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         ovf_ff <= 1'b0;
      end else begin
         ovf_ff <= ovf_ev || (ovf_ff && !ovf_clr);
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         unf_ff <= 1'b0;
      end else begin
         unf_ff <= unf_ev || (unf_ff && !unf_clr);
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         fault_ff <= 1'b0;
      end else begin
         fault_ff <= idx_restore;
      end
   end

   // ----------------------------------------
   // register read
   // ----------------------------------------
   // read data is zero outside the cycle after a read strobe
   always_comb begin
      nxt_rdata = 8'h00;
      if (i_bus.rd) begin
         unique case (i_bus.addr)
            prs_pkg::ADDR_PCL: nxt_rdata = pc_ff[7:0];
            prs_pkg::ADDR_LATCH: nxt_rdata = {1'b0, latch_ff};
            prs_pkg::ADDR_INDEX: nxt_rdata = {3'h0, idx_ff};
            prs_pkg::ADDR_TOP_OF_STACK_LOW: nxt_rdata = tos[7:0];
            prs_pkg::ADDR_TOP_OF_STACK_HIGH: nxt_rdata = {1'b0, tos[14:8]};
            prs_pkg::ADDR_STATUS: nxt_rdata = {6'h00, unf_ff, ovf_ff};
            default: nxt_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         rdata_ff <= 8'h00;
      end else begin
         rdata_ff <= nxt_rdata;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign o_rdata = rdata_ff;
   assign o_pc = pc_ff;
   assign o_stack_overflow_flag = ovf_ff;
   assign o_stack_underflow_flag = unf_ff;
   assign o_stack_fault_reset = fault_ff;

endmodule : prs_pc_stack

// ----------------------------------------
// one return stack entry
// ----------------------------------------
module prs_stack_slot (
   // clock
   input wire logic i_clk,
   // write controls
   input wire logic i_push_wr,
   input wire logic i_lo_wr,
   input wire logic i_hi_wr,
   // write data
   input wire logic [prs_pkg::PC_W-1:0] i_push_data,
   input wire logic [7:0] i_wdata,
   // stored return address
   output logic [prs_pkg::PC_W-1:0] o_q
);

   logic [prs_pkg::PC_W-1:0] q_ff;

   // entries are not reset: emptiness lives in the index, not the contents
   always_ff @(posedge i_clk) begin
      if (i_push_wr) begin
         q_ff <= i_push_data;
      end else if (i_lo_wr) begin
         q_ff[7:0] <= i_wdata;
      end else if (i_hi_wr) begin
         q_ff[14:8] <= i_wdata[6:0];
      end
   end

   assign o_q = q_ff;

endmodule : prs_stack_slot

// *** design/prs_pkg.sv ***
// constants and types for the program counter and return stack
// ----------------------------------------
// Overview of operation
// - fifteen-bit counter; low byte software visible, upper seven written by software only through latch
// - every reset clears the whole counter to zero
// - writing the low byte also loads counter bits 14..8 from the latch
// - subroutine jump: operand gives low byte and bits 10..8, latch gives 14..11
// - indirect subroutine jump: working register gives low byte, latch gives upper part
// - accumulator branch: counter becomes counter plus one plus unsigned working register
// - literal branch: counter becomes counter plus one plus signed operand
// - return stack holds sixteen entries of fifteen bits, outside memory spaces
// - push on jumps and interrupt vectoring; pop on the one return request, PRS_OP_RET
// - pushes and pops never change the high latch
// - fault reset off: stack wraps, seventeenth push overwrites the first entry
// - overflow and underflow flags set whether or not fault reset is on
// - stack index is five bits so overflow and underflow are visible
// - top-of-stack registers access the entry the stack index selects, but read zero with fault reset on and stack empty
// - push increments index then writes; pop reads then decrements
// - after reset the stack is empty with index 0x1f
// - fault reset off and stack empty: top-of-stack reads give entry 0x0f
// - fault reset on: overflow or underflow requests a device reset
// ----------------------------------------
package prs_pkg;

   localparam int PC_W = 15;
   localparam int HI_W = 7;
   localparam int IDX_W = 5;
   localparam int DEPTH = 16;

   // ----------------------------------------
   // register map
   // ----------------------------------------
   localparam logic [2:0] ADDR_PCL = 3'h0;
   localparam logic [2:0] ADDR_LATCH = 3'h1;
   localparam logic [2:0] ADDR_INDEX = 3'h2;
   localparam logic [2:0] ADDR_TOP_OF_STACK_LOW = 3'h3;
   localparam logic [2:0] ADDR_TOP_OF_STACK_HIGH = 3'h4;
   localparam logic [2:0] ADDR_STATUS = 3'h5;

   // status register bits
   localparam int ST_OVF_BIT = 0;
   localparam int ST_UNF_BIT = 1;

   localparam logic [IDX_W-1:0] IDX_EMPTY = 5'h1f;
   localparam logic [IDX_W-1:0] IDX_TOP = 5'h0f;
   localparam logic [PC_W-1:0] PC_RST = 15'h0000;
   localparam logic [HI_W-1:0] LATCH_RST = 7'h00;

   // counter load requests from the execute logic
   typedef enum logic [2:0] {
      PRS_OP_NONE = 3'h0,
      PRS_OP_CALL = 3'h1,
      PRS_OP_INDIRECT_SUBROUTINE_JUMP = 3'h2,
      PRS_OP_BRW = 3'h3,
      PRS_OP_BRA = 3'h4,
      PRS_OP_RET = 3'h5,
      PRS_OP_IRQ = 3'h6,
      PRS_OP_INC = 3'h7
   } prs_op_t;

   typedef struct packed {
      prs_op_t op;
      logic [10:0] operand;
      logic [7:0] wreg;
      logic [PC_W-1:0] vector;
   } prs_cmd_t;

   typedef struct packed {
      logic [2:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } prs_bus_t;

endpackage : prs_pkg

// *** verif/prs_pc_stack_chk.sv ***
// assertion checker for the counter and return stack ports
`timescale 1ns/1ps
module prs_pc_stack_chk (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_srst,
   // inputs
   input wire logic i_stack_fault_reset_enable,
   input wire prs_pkg::prs_cmd_t i_cmd,
   input wire prs_pkg::prs_bus_t i_bus,
   // outputs
   input wire logic [7:0] o_rdata,
   input wire logic [prs_pkg::PC_W-1:0] o_pc,
   input wire logic o_stack_overflow_flag,
   input wire logic o_stack_underflow_flag,
   input wire logic o_stack_fault_reset
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_srst);
   logic wpcl;
   assign wpcl = i_bus.wr && i_bus.addr == prs_pkg::ADDR_PCL;
   property p_rst;
      disable iff (1'b0) i_srst |=> o_pc == 15'h0000 && !o_stack_overflow_flag && !o_stack_underflow_flag;
   endproperty
   a_rst: assert property (p_rst) else $error("counter not cleared by reset");
   property p_pcl;
      wpcl |=> o_pc[7:0] == $past(i_bus.wdata);
   endproperty
   a_pcl: assert property (p_pcl) else $error("low byte write lost");
   property p_call;
      i_cmd.op == prs_pkg::PRS_OP_CALL && !wpcl |=> o_pc[10:0] == $past(i_cmd.operand);
   endproperty
   a_call: assert property (p_call) else $error("jump target wrong");
   property p_indirect_subroutine_jump;
      i_cmd.op == prs_pkg::PRS_OP_INDIRECT_SUBROUTINE_JUMP && !wpcl |=> o_pc[7:0] == $past(i_cmd.wreg);
   endproperty
   a_indirect_subroutine_jump: assert property (p_indirect_subroutine_jump) else $error("indirect jump target wrong");
   property p_brw;
      i_cmd.op == prs_pkg::PRS_OP_BRW && !wpcl |=> o_pc == $past(o_pc) + 15'h0001 + {7'h00, $past(i_cmd.wreg)};
   endproperty
   a_brw: assert property (p_brw) else $error("accumulator branch wrong");
   property p_bra;
      i_cmd.op == prs_pkg::PRS_OP_BRA && !wpcl |=>
         o_pc == $past(o_pc) + 15'h0001 + {{6{$past(i_cmd.operand[8])}}, $past(i_cmd.operand[8:0])};
   endproperty
   a_bra: assert property (p_bra) else $error("literal branch wrong");
   property p_irq;
      i_cmd.op == prs_pkg::PRS_OP_IRQ && !wpcl |=> o_pc == $past(i_cmd.vector);
   endproperty
   a_irq: assert property (p_irq) else $error("vector not loaded");
   property p_flt;
      o_stack_fault_reset |-> $past(i_stack_fault_reset_enable) && (o_stack_overflow_flag || o_stack_underflow_flag);
   endproperty
   a_flt: assert property (p_flt) else $error("fault reset without cause");
endmodule : prs_pc_stack_chk
bind prs_pc_stack prs_pc_stack_chk u_chk (.i_clk, .i_srst, .i_stack_fault_reset_enable, .i_cmd, .i_bus,
   .o_rdata, .o_pc, .o_stack_overflow_flag, .o_stack_underflow_flag, .o_stack_fault_reset);

// *** verif/prs_exec_model.sv ***
// execute-side model: one counter request per call, idle between
`timescale 1ns/1ps
module prs_exec_model (
   // clock
   input wire logic i_clk,
   // request to the counter block
   output prs_pkg::prs_cmd_t o_cmd
);
   initial o_cmd = '0;
   // only issues on demand, so no interrupt push lands during an index change
   task automatic issue(input prs_pkg::prs_op_t op, input logic [10:0] opd, input logic [7:0] w);
      @(posedge i_clk);
      o_cmd <= '{op, opd, w, 15'h4321};
      @(posedge i_clk);
      o_cmd <= '0;
      #1;
   endtask : issue
endmodule : prs_exec_model

// *** verif/prs_pc_stack_tb.sv ***
// self-checking bench for the counter and return stack
`timescale 1ns/1ps
module prs_pc_stack_tb;
   logic i_clk = 1'b0;
   logic i_srst = 1'b1;
   logic en = 1'b0;
   prs_pkg::prs_cmd_t cmd;
   prs_pkg::prs_bus_t bus = '0;
   logic [7:0] rdata;
   logic [14:0] pc;
   logic ovf, unf, flt;
   logic flt_seen = 1'b0;
   logic [14:0] q [3] = '{15'h2a12, 15'h2da6, 15'h2a35};
   int n_mismatch = 0;
   int n_checks = 0;
   always #50 i_clk = ~i_clk;
   always @(posedge i_clk) if (flt) flt_seen <= 1'b1;
   prs_exec_model u_exec (.i_clk, .o_cmd(cmd));
   prs_pc_stack u_dut (.i_clk, .i_srst, .i_stack_fault_reset_enable(en), .i_cmd(cmd), .i_bus(bus),
      .o_rdata(rdata), .o_pc(pc), .o_stack_overflow_flag(ovf), .o_stack_underflow_flag(unf),
      .o_stack_fault_reset(flt));
   task automatic test_done();
      if (n_mismatch == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : test_done
   task automatic chk(input logic [14:0] got, input logic [14:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("FAIL %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge i_clk);
      bus <= '{a, d, 1'b1, 1'b0};
      @(posedge i_clk);
      bus <= '0;
      #1;
   endtask : wr
   task automatic rd(input logic [2:0] a, input logic [7:0] e);
      @(posedge i_clk);
      bus <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge i_clk);
      bus <= '0;
      #1;
      chk({7'h00, rdata}, {7'h00, e});
   endtask : rd
   task automatic tos(input logic [14:0] e);
      rd(prs_pkg::ADDR_TOP_OF_STACK_LOW, e[7:0]);
      rd(prs_pkg::ADDR_TOP_OF_STACK_HIGH, {1'b0, e[14:8]});
   endtask : tos
   task automatic rst();
      i_srst <= 1'b1;
      repeat (8) @(posedge i_clk);
      i_srst <= 1'b0;
      #1;
      chk(pc, 15'h0000);
   endtask : rst
   initial begin
      rst();
      rd(prs_pkg::ADDR_INDEX, 8'h1f);
      wr(prs_pkg::ADDR_LATCH, 8'h2a);
      wr(prs_pkg::ADDR_PCL, 8'h34);
      chk(pc, 15'h2a34);
      rd(prs_pkg::ADDR_PCL, 8'h34);
      u_exec.issue(prs_pkg::PRS_OP_CALL, 11'h5a5, 8'h00);
      chk(pc, 15'h2da5);
      rd(prs_pkg::ADDR_INDEX, 8'h00);
      tos(15'h2a35);
      u_exec.issue(prs_pkg::PRS_OP_INDIRECT_SUBROUTINE_JUMP, 11'h000, 8'h11);
      chk(pc, 15'h2a11);
      u_exec.issue(prs_pkg::PRS_OP_IRQ, 11'h000, 8'h00);
      chk(pc, 15'h4321);
      tos(15'h2a12);
      foreach (q[i]) begin
         u_exec.issue(prs_pkg::PRS_OP_RET, 11'h000, 8'h00);
         chk(pc, q[i]);
      end
      rd(prs_pkg::ADDR_LATCH, 8'h2a);
      u_exec.issue(prs_pkg::PRS_OP_BRW, 11'h000, 8'hff);
      chk(pc, 15'h2b35);
      u_exec.issue(prs_pkg::PRS_OP_BRA, 11'h100, 8'h00);
      chk(pc, 15'h2a36);
      u_exec.issue(prs_pkg::PRS_OP_INC, 11'h000, 8'h00);
      chk(pc, 15'h2a37);
      rst();
      for (int k = 0; k < 17; k++)
         u_exec.issue(prs_pkg::PRS_OP_CALL, 11'(k), 8'h00);
      chk({14'h0000, ovf}, 15'h0001);
      rd(prs_pkg::ADDR_INDEX, 8'h10);
      tos(15'h0010);
      chk({14'h0000, flt_seen}, 15'h0000);
      wr(prs_pkg::ADDR_INDEX, 8'h0f);
      wr(prs_pkg::ADDR_TOP_OF_STACK_LOW, 8'h77);
      wr(prs_pkg::ADDR_TOP_OF_STACK_HIGH, 8'h12);
      wr(prs_pkg::ADDR_INDEX, 8'h1f);
      tos(15'h1277);
      @(posedge i_clk);
      en <= 1'b1;
      tos(15'h0000);
      u_exec.issue(prs_pkg::PRS_OP_RET, 11'h000, 8'h00);
      chk(pc, 15'h0000);
      repeat (2) @(posedge i_clk);
      #1;
      chk({13'h0000, unf, flt_seen}, 15'h0003);
      rd(prs_pkg::ADDR_INDEX, 8'h1f);
      rd(prs_pkg::ADDR_STATUS, 8'h03);
      wr(prs_pkg::ADDR_STATUS, 8'h00);
      rd(prs_pkg::ADDR_STATUS, 8'h00);
      test_done();
   end
   initial begin
      #200000;
      n_mismatch++;
      test_done();
   end
endmodule : prs_pc_stack_tb
